/* File: rtl/bcast_rx_status.sv */
// Operation
// - Broadcast frame: broadcast bit 0 and slave address general or own group.
// - Post start code after length field when buffer was ready at control.
// - At start, push master address, control bits and length into buffer.
// - Post buffer-full code when a received byte cannot be stored.
// - Abort reception if host frees no byte within the full wait time.
// - Post normal-end code after all bytes, then clear receive enable.
// - Post abort code when frame ends short, then clear receive enable.
// - After end or abort, publish data byte count; data stays readable.
// - With error option, post error code if buffer not ready at control.
// - On reception error, store master address bits 7:0 in error register 1 and bits 11:8 in error register 2.
// - Error registers are overwritten on every error; host reads them promptly.
// - Single-frame option: ready only when enable set and buffer empty.
// - Multi-frame option: ready when enable set and four bytes free.
// - While ready, send slave status bit 1 as zero.
// - Receive buffer holds forty bytes of headers and data.
// - Byte count holds only correctly received data bytes.
`timescale 1ns/1ps
`default_nettype none
module bcast_rx_status #(
	parameter int BUF_WAIT_M0 = bcast_rx_pkg::BUF_WAIT_M0_CYC,
	parameter int BUF_WAIT_M1 = bcast_rx_pkg::BUF_WAIT_M1_CYC
) (
	// Clock and reset
	input  wire logic                              CLK_SYS,
	input  wire logic                              RST,
	// Configuration
	input  wire logic                              MODE,
	input  wire logic [bcast_rx_pkg::ADDR_W-1:0]   GROUP_ADDR,
	input  wire logic                              BCAST_ERROR_CODE_ENABLE,
	input  wire logic                              MULTI_FRAME_CAPTURE_ENABLE,
	input  wire logic                              SLAVE_RECEIVE_ENABLE_SET,
	input  wire logic                              IRQ_CLR,
	// Frame events from the link layer
	input  wire logic                              FRM_HDR,
	input  wire logic                              FRM_BCAST_BIT,
	input  wire logic [bcast_rx_pkg::ADDR_W-1:0]   FRM_SLAVE_ADDR,
	input  wire logic [bcast_rx_pkg::ADDR_W-1:0]   FRM_MASTER_ADDR,
	input  wire logic                              FRM_CTRL_VALID,
	input  wire logic [3:0]                        FRM_CTRL,
	input  wire logic                              FRM_LEN_VALID,
	input  wire logic [7:0]                        FRM_LEN,
	input  wire logic                              FRM_ABORT,
	// Received data bytes
	input  wire logic                              DATA_VALID,
	input  wire logic [7:0]                        DATA,
	output logic                                   DATA_READY,
	// Slave status towards the bus
	output logic                                   STATUS_RX_BUSY,
	// Host side
	output logic [3:0]                             SLAVE_RETURN_CODE_FIELD,
	output logic                                   IRQ,
	output logic                                   SLAVE_RECEIVE_ENABLE_FLAG,
	output logic [7:0]                             SLAVE_RX_BYTE_COUNT,
	output logic [7:0]                             BCAST_ERROR_ADDRESS_1,
	output logic [7:0]                             BCAST_ERROR_ADDRESS_2,
	input  wire logic                              RD_REQ,
	output logic [7:0]                             RD_DATA,
	output logic                                   RD_VALID,
	output logic                                   FIFO_EMPTY,
	output logic [bcast_rx_pkg::LVL_W-1:0]         FIFO_LEVEL
);
	import bcast_rx_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_LEN, ST_HDR, ST_DATA} state_e;
	typedef struct packed {
		state_e          st;
		logic [1:0]      hdr_idx;
		logic            abort_pend;
		logic [11:0]     maddr;
		logic [3:0]      ctrl;
		logic [7:0]      len;
		logic [7:0]      cnt;
		logic [1:0][7:0] buf_data;
		logic [1:0]      buf_cnt;
		logic [TMR_W-1:0] timer;
		logic            full_posted;
		logic [3:0]      rc;
		logic            irq;
		logic            slave_receive_enable_flag;
		logic [7:0]      byte_count;
		logic [7:0]      err_addr_1;
		logic [7:0]      err_addr_2;
		logic            not_ready;
	} status_s;
	status_s          r;
	status_s          next_r;
	logic             fifo_wr_ready;
	logic [LVL_W-1:0] fifo_level;
	logic             fifo_ready;
	logic             stalled;
	logic             timeout;
	logic             push;
	logic [7:0]       push_data;
	logic             pop;
	logic [TMR_W-1:0] wait_limit;
	////////////////////////////////////////////////////////////////////////////////
	// Decoding
	function automatic logic is_bcast(input logic bbit, input logic [11:0] saddr,
		input logic [11:0] group);
		is_bcast = (bbit == BCAST_BIT_VAL) && ((saddr == ADDR_GENERAL) || (saddr == group));
	endfunction
	// Bytes still in the skid buffer count as used space
	function automatic logic space_ok(input logic [LVL_W-1:0] lvl, input logic [1:0] held,
		input logic multi_frame_capture_enable);
		logic [LVL_W:0] used;
		used = {1'b0, lvl} + {{(LVL_W-1){1'b0}}, held};
		if (multi_frame_capture_enable)
			space_ok = (used <= (LVL_W+1)'(FIFO_DEPTH - MIN_FREE));
		else
			space_ok = (used == '0);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Ready, stall and timeout
	// Readiness
	// Buffer ready test
	assign fifo_ready = r.slave_receive_enable_flag && space_ok(fifo_level, r.buf_cnt, MULTI_FRAME_CAPTURE_ENABLE);
	// A full skid buffer behind a full FIFO is the point where a byte is refused
	assign stalled    = (r.st == ST_DATA) && (r.buf_cnt == 2'd2) && !fifo_wr_ready;
	assign wait_limit = MODE ? TMR_W'(BUF_WAIT_M1 - 1) : TMR_W'(BUF_WAIT_M0 - 1);
	assign timeout    = stalled && (r.timer >= wait_limit);
	assign pop        = (r.buf_cnt != 2'd0) && fifo_wr_ready;
	assign DATA_READY = (r.st == ST_DATA) && (r.buf_cnt != 2'd2) && (r.cnt != r.len);
	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		next_r           = r;
		push             = 1'b0;
		push_data        = 8'h00;
		next_r.not_ready = !fifo_ready;
		next_r.irq       = r.irq && !IRQ_CLR;
		case (r.st)
			ST_IDLE:
			begin
				if (FRM_HDR && is_bcast(FRM_BCAST_BIT, FRM_SLAVE_ADDR, GROUP_ADDR))
				begin
					next_r.st    = ST_CTRL;
					next_r.maddr = FRM_MASTER_ADDR;
				end
			end
			ST_CTRL:
			begin
				if (FRM_ABORT)
					next_r.st = ST_IDLE;
				else if (FRM_CTRL_VALID)
				begin
					next_r.ctrl = FRM_CTRL;
					if (fifo_ready)
						next_r.st = ST_LEN;
					else
					begin
						next_r.st = ST_IDLE;
						if (BCAST_ERROR_CODE_ENABLE)
						begin
							next_r.rc         = RC_BC_ERROR;
							next_r.irq        = 1'b1;
							next_r.err_addr_1 = r.maddr[7:0];
							next_r.err_addr_2 = {4'h0, r.maddr[11:8]};
						end
					end
				end
			end
			ST_LEN:
			begin
				if (FRM_ABORT)
					next_r.st = ST_IDLE;
				else if (FRM_LEN_VALID)
				begin
					next_r.rc          = RC_BC_START;
					next_r.irq         = 1'b1;
					next_r.len         = FRM_LEN;
					next_r.cnt         = 8'h00;
					next_r.hdr_idx     = 2'd0;
					next_r.abort_pend  = 1'b0;
					next_r.full_posted = 1'b0;
					next_r.timer       = '0;
					next_r.st          = ST_HDR;
				end
			end
			ST_HDR:
			begin
				// Link stalls on DATA_READY here, but an abort may still arrive
				if (FRM_ABORT)
					next_r.abort_pend = 1'b1;
				if (r.buf_cnt != 2'd2)
				begin
					push = 1'b1;
					case (r.hdr_idx)
						2'd0:    push_data = r.maddr[11:4];
						2'd1:    push_data = {r.maddr[3:0], r.ctrl};
						default: push_data = r.len;
					endcase
					next_r.hdr_idx = r.hdr_idx + 2'd1;
					if (r.hdr_idx == 2'(HDR_BYTES - 1))
						next_r.st = ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (r.cnt == r.len)
				begin
					next_r.rc         = RC_BC_END;
					next_r.irq        = 1'b1;
					next_r.slave_receive_enable_flag       = 1'b0;
					next_r.byte_count = r.cnt;
					next_r.st         = ST_IDLE;
				end
				else if (FRM_ABORT || r.abort_pend || timeout)
				begin
					next_r.rc         = RC_BC_ABORT;
					next_r.irq        = 1'b1;
					next_r.slave_receive_enable_flag       = 1'b0;
					next_r.byte_count = r.cnt;
					next_r.st         = ST_IDLE;
				end
				else
				begin
					if (stalled)
					begin
						next_r.timer = r.timer + 1'b1;
						if (!r.full_posted)
						begin
							next_r.rc          = RC_BC_FULL;
							next_r.irq         = 1'b1;
							next_r.full_posted = 1'b1;
						end
					end
					else
					begin
						next_r.timer       = '0;
						next_r.full_posted = 1'b0;
					end
					if (DATA_VALID && DATA_READY)
					begin
						push       = 1'b1;
						push_data  = DATA;
						next_r.cnt = r.cnt + 8'h01;
					end
				end
			end
			default:
				next_r.st = ST_IDLE;
		endcase
		// Two-entry skid buffer; pop first so a push can reuse the slot
		if (pop)
		begin
			next_r.buf_data[0] = r.buf_data[1];
			next_r.buf_cnt     = r.buf_cnt - 2'd1;
		end
		if (push)
		begin
			next_r.buf_data[next_r.buf_cnt[0]] = push_data;
			next_r.buf_cnt                     = next_r.buf_cnt + 2'd1;
		end
		// Host set wins over the clear at the end of a frame
		if (SLAVE_RECEIVE_ENABLE_SET)
			next_r.slave_receive_enable_flag = 1'b1;
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
		begin
			r            <= '0;
			r.st         <= ST_IDLE;
			r.rc         <= RC_RESET;
			r.byte_count <= BYTE_RESET;
			r.err_addr_1 <= BYTE_RESET;
			r.err_addr_2 <= BYTE_RESET;
			r.not_ready  <= 1'b1;
		end
		else
			r <= next_r;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Receive buffer
	// Forty-byte receive buffer
	bcast_rx_fifo #(
		.DEPTH (FIFO_DEPTH),
		.WIDTH (FIFO_WIDTH)
	) u_fifo (
		.clk      (CLK_SYS),
		.rst      (RST),
		.wr_valid (r.buf_cnt != 2'd0),
		.wr_data  (r.buf_data[0]),
		.wr_ready (fifo_wr_ready),
		.rd_req   (RD_REQ),
		.rd_data  (RD_DATA),
		.rd_valid (RD_VALID),
		.empty    (FIFO_EMPTY),
		.level    (fifo_level)
	);
	assign SLAVE_RETURN_CODE_FIELD   = r.rc;
	assign IRQ                       = r.irq;
	assign SLAVE_RECEIVE_ENABLE_FLAG = r.slave_receive_enable_flag;
	assign SLAVE_RX_BYTE_COUNT       = r.byte_count;
	assign BCAST_ERROR_ADDRESS_1     = r.err_addr_1;
	assign BCAST_ERROR_ADDRESS_2     = r.err_addr_2;
	assign STATUS_RX_BUSY            = r.not_ready;
	assign FIFO_LEVEL                = fifo_level;
	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_ignore_non_bcast: assert property (
		(r.st == ST_IDLE && FRM_HDR && FRM_BCAST_BIT) |=> (r.st == ST_IDLE))
		else $error("non-broadcast frame was taken");
	a_start_code: assert property (
		(r.st == ST_LEN && FRM_LEN_VALID && !FRM_ABORT)
		|=> (SLAVE_RETURN_CODE_FIELD == RC_BC_START) && IRQ)
		else $error("start code missing after length field");
	a_header_three: assert property (
		(r.st == ST_LEN && FRM_LEN_VALID && !FRM_ABORT && r.buf_cnt == 2'd0)
		|=> (r.st == ST_HDR)[*3] ##1 (r.st != ST_HDR))
		else $error("header push did not take three cycles");
	a_full_code: assert property (
		(stalled && !r.full_posted && !timeout && r.cnt != r.len && !FRM_ABORT
		&& !r.abort_pend) |=> (SLAVE_RETURN_CODE_FIELD == RC_BC_FULL))
		else $error("buffer-full code missing");
	a_full_timeout: assert property (
		(timeout && r.cnt != r.len && !SLAVE_RECEIVE_ENABLE_SET)
		|=> (SLAVE_RETURN_CODE_FIELD == RC_BC_ABORT) && !SLAVE_RECEIVE_ENABLE_FLAG)
		else $error("timeout did not abort reception");
	a_end_code: assert property (
		(r.st == ST_DATA && r.cnt == r.len && !SLAVE_RECEIVE_ENABLE_SET)
		|=> (SLAVE_RETURN_CODE_FIELD == RC_BC_END) && !SLAVE_RECEIVE_ENABLE_FLAG)
		else $error("normal end code or flag clear missing");
	a_abort_code: assert property (
		(r.st == ST_DATA && r.cnt != r.len && FRM_ABORT)
		|=> (SLAVE_RETURN_CODE_FIELD == RC_BC_ABORT) && (r.st == ST_IDLE))
		else $error("abort code missing on short frame");
	a_byte_count: assert property (
		(r.st == ST_DATA && r.cnt == r.len) |=> (SLAVE_RX_BYTE_COUNT == $past(r.len)))
		else $error("byte count differs from length after normal end");
	a_error_addr: assert property (
		(r.st == ST_CTRL && FRM_CTRL_VALID && !FRM_ABORT && !fifo_ready
		&& BCAST_ERROR_CODE_ENABLE) |=> (SLAVE_RETURN_CODE_FIELD == RC_BC_ERROR)
		&& (BCAST_ERROR_ADDRESS_1 == $past(r.maddr[7:0])))
		else $error("error code or address not posted");
	a_single_frame: assert property (
		(!MULTI_FRAME_CAPTURE_ENABLE && fifo_level != '0) |-> !fifo_ready)
		else $error("ready while buffer not empty");
	a_multi_frame: assert property (
		(MULTI_FRAME_CAPTURE_ENABLE && r.slave_receive_enable_flag && r.buf_cnt == 2'd0
		&& fifo_level <= LVL_W'(FIFO_DEPTH - MIN_FREE)) |-> fifo_ready)
		else $error("not ready with four bytes free");
	a_status_bit: assert property (
		##1 (STATUS_RX_BUSY == !$past(fifo_ready)))
		else $error("status bit does not follow readiness");
	a_irq_raise: assert property (
		(next_r.rc != r.rc) |=> IRQ)
		else $error("new code without interrupt");
endmodule
`default_nettype wire

/* File: rtl/bcast_rx_pkg.sv */
`default_nettype none
package bcast_rx_pkg;
	// Clock and link timing
	localparam int CLK_MHZ            = 200;
	localparam int BUF_WAIT_M0_US     = 1570;
	localparam int BUF_WAIT_M1_US     = 390;
	localparam int BUF_WAIT_M0_CYC    = BUF_WAIT_M0_US * CLK_MHZ;
	localparam int BUF_WAIT_M1_CYC    = BUF_WAIT_M1_US * CLK_MHZ;
	localparam int TMR_W              = 19;

	// Receive buffer geometry
	localparam int FIFO_DEPTH         = 40;
	localparam int FIFO_WIDTH         = 8;
	localparam int LVL_W              = 6;
	localparam int HDR_BYTES          = 3;
	localparam int MIN_FREE           = 4;

	// Frame fields
	localparam int ADDR_W             = 12;
	localparam logic [11:0] ADDR_GENERAL = 12'h0ff;
	localparam logic        BCAST_BIT_VAL = 1'h0;

	// Return codes of broadcast reception
	localparam logic [3:0] RC_BC_START = 4'h8;
	localparam logic [3:0] RC_BC_FULL  = 4'h9;
	localparam logic [3:0] RC_BC_END   = 4'ha;
	localparam logic [3:0] RC_BC_ABORT = 4'hb;
	localparam logic [3:0] RC_BC_ERROR = 4'hc;

	// Reset values
	localparam logic [3:0] RC_RESET    = 4'h0;
	localparam logic [7:0] BYTE_RESET  = 8'h00;
endpackage
`default_nettype wire

/* File: rtl/bcast_rx_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module bcast_rx_fifo #(
	parameter int DEPTH = bcast_rx_pkg::FIFO_DEPTH,
	parameter int WIDTH = bcast_rx_pkg::FIFO_WIDTH
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Write side
	input  wire logic                      wr_valid,
	input  wire logic [WIDTH-1:0]          wr_data,
	output logic                           wr_ready,
	// Read side
	input  wire logic                      rd_req,
	output logic [WIDTH-1:0]               rd_data,
	output logic                           rd_valid,
	output logic                           empty,
	output logic [$clog2(DEPTH+1)-1:0]     level
);
	import bcast_rx_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [LW-1:0]               level;
		logic [WIDTH-1:0]            rd_data;
		logic                        rd_valid;
	} fifo_s;

	fifo_s r;
	fifo_s next_r;
	logic  do_wr;
	logic  do_rd;

	// Depth need not be a power of two, so wrap by hand
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == LAST) ? '0 : p + 1'b1;
	endfunction

	assign wr_ready = (r.level != LW'(DEPTH));
	assign do_wr    = wr_valid && wr_ready;
	assign do_rd    = rd_req && (r.level != '0);

	always_comb
	begin
		next_r          = r;
		next_r.rd_valid = do_rd;
		if (do_wr)
		begin
			next_r.mem[r.wr_ptr] = wr_data;
			next_r.wr_ptr        = ptr_inc(r.wr_ptr);
		end
		if (do_rd)
		begin
			next_r.rd_data = r.mem[r.rd_ptr];
			next_r.rd_ptr  = ptr_inc(r.rd_ptr);
		end
		if (do_wr && !do_rd)
			next_r.level = r.level + 1'b1;
		else if (do_rd && !do_wr)
			next_r.level = r.level - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= '0;
		else
			r <= next_r;
	end

	assign rd_data  = r.rd_data;
	assign rd_valid = r.rd_valid;
	assign empty    = (r.level == '0);
	assign level    = r.level;

	// Depth bound
	a_fifo_depth_bound: assert property (@(posedge clk) disable iff (rst)
		r.level <= LW'(DEPTH))
		else $error("receive buffer level above its depth");
endmodule
`default_nettype wire

/* File: bench/far_master.sv */
`timescale 1ns/1ps
`default_nettype none
module far_master
(
	// Clock
	input  wire logic        clk,
	// Frame events
	output logic             hdr,
	output logic             bb,
	output logic [11:0]      sa,
	output logic [11:0]      ma,
	output logic             cv,
	output logic [3:0]       ctl,
	output logic             lv,
	output logic [7:0]       len,
	output logic             ab,
	// Data bytes
	output logic             dv,
	output logic [7:0]       dat,
	input  wire logic        dr
);
	initial
	begin
		{hdr, cv, lv, ab, dv} = 5'h00;
		{bb, sa, ma, ctl, len, dat} = 45'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Header, control, length
	// Called just after a rising edge; released fields flip so stale values never match
	task automatic send(input logic b, input logic [11:0] s, m, input logic [3:0] c,
		input logic [7:0] l, input int nb, input logic cut);
		int w;
		hdr = 1'h1;
		{bb, sa, ma} = {b, s, m};
		@(posedge clk);
		#1;
		{hdr, cv, ctl} = {1'h0, 1'h1, c};
		{bb, sa, ma} = ~{bb, sa, ma};
		@(posedge clk);
		#1;
		{cv, lv, len} = {1'h0, 1'h1, l};
		ctl = ~ctl;
		@(posedge clk);
		#1;
		lv = 1'h0;
		len = ~len;
		w = 0;
		// A byte left unaccepted too long is given up, as a bus master would
		for (int i = 0; i < nb && w < 300; i++)
		begin
			dv = 1'h1;
			dat = 8'hd0 + 8'(i);
			w = 0;
			#1;
			while (dr !== 1'h1 && w < 300)
			begin
				@(posedge clk);
				#2;
				w++;
			end
			@(posedge clk);
			#1;
		end
		dv = 1'h0;
		dat = ~dat;
		if (cut)
		begin
			ab = 1'h1;
			@(posedge clk);
			#1;
			ab = 1'h0;
		end
	endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bcast_rx_pkg::*;
	logic             clk = 1'h0, rst = 1'h1, mode = 1'h0, err_en = 1'h0, multi_frame_capture_enable = 1'h0;
	logic             en_set = 1'h0, irq_clr = 1'h0, rd_req = 1'h0;
	logic [11:0]      grp = 12'h3c5;
	logic             hdr, bb, cv, lv, ab, dv, dr, busy, irq, flag, rv, empty;
	logic [11:0]      sa, ma;
	logic [3:0]       ctl, code;
	logic [7:0]       len, dat, cnt, ea1, ea2, rdat;
	logic [LVL_W-1:0] lvl;
	int               mismatches = 0, check_count = 0, cyc = 0, n, w;
	always #2.5 clk = ~clk;
	far_master u_far(.clk(clk), .hdr(hdr), .bb(bb), .sa(sa), .ma(ma), .cv(cv), .ctl(ctl),
		.lv(lv), .len(len), .ab(ab), .dv(dv), .dat(dat), .dr(dr));
	// Short stall waits keep the run brief
	bcast_rx_status #(.BUF_WAIT_M0(20), .BUF_WAIT_M1(10)) u_dut(.CLK_SYS(clk), .RST(rst),
		.MODE(mode), .GROUP_ADDR(grp), .BCAST_ERROR_CODE_ENABLE(err_en),
		.MULTI_FRAME_CAPTURE_ENABLE(multi_frame_capture_enable), .SLAVE_RECEIVE_ENABLE_SET(en_set),
		.IRQ_CLR(irq_clr), .FRM_HDR(hdr), .FRM_BCAST_BIT(bb), .FRM_SLAVE_ADDR(sa),
		.FRM_MASTER_ADDR(ma), .FRM_CTRL_VALID(cv), .FRM_CTRL(ctl), .FRM_LEN_VALID(lv),
		.FRM_LEN(len), .FRM_ABORT(ab), .DATA_VALID(dv), .DATA(dat), .DATA_READY(dr),
		.STATUS_RX_BUSY(busy), .SLAVE_RETURN_CODE_FIELD(code), .IRQ(irq),
		.SLAVE_RECEIVE_ENABLE_FLAG(flag), .SLAVE_RX_BYTE_COUNT(cnt),
		.BCAST_ERROR_ADDRESS_1(ea1), .BCAST_ERROR_ADDRESS_2(ea2), .RD_REQ(rd_req),
		.RD_DATA(rdat), .RD_VALID(rv), .FIFO_EMPTY(empty), .FIFO_LEVEL(lvl));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic wait_code(input logic [3:0] e);
		n = 0;
		while (!(irq === 1'h1 && code === e) && n < 400)
		begin
			tick;
			n++;
		end
		chk("code", {8'h0, code}, {8'h0, e});
		chk("irq", {11'h0, irq}, 12'h001);
		irq_clr = 1'h1;
		tick;
		irq_clr = 1'h0;
	endtask
	task automatic frame(input logic [11:0] s, m, input logic [3:0] c, input logic [7:0] l,
		input int nb, input logic cut, input logic [3:0] c1, c2);
		fork
			u_far.send(1'h0, s, m, c, l, nb, cut);
			begin
				wait_code(c1);
				if (c2 != RC_RESET)
					wait_code(c2);
			end
		join
	endtask
	task automatic rd(input logic [7:0] e);
		rd_req = 1'h1;
		tick;
		rd_req = 1'h0;
		if (rv !== 1'h1)
			tick;
		chk("rd_valid", {11'h0, rv}, 12'h001);
		chk("rd_data", {4'h0, rdat}, {4'h0, e});
		tick;
	endtask
	task automatic drain;
		for (int i = 0; i < 60 && empty !== 1'h1; i++)
		begin
			rd_req = 1'h1;
			tick;
			rd_req = 1'h0;
			tick;
		end
	endtask
	task automatic set_en;
		en_set = 1'h1;
		tick;
		en_set = 1'h0;
		tick;
		tick;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc >= 20000)
		begin
			mismatches++;
			wrap_up;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'h0;
		tick;
		chk("idle", {4'h0, code, irq, flag, busy, empty}, 12'h003);
		chk("err addr 1", {4'h0, ea1}, 12'h000);
		chk("err addr 2", {4'h0, ea2}, 12'h000);
		chk("count", {4'h0, cnt}, 12'h000);
		$display("test reset done");
		set_en;
		chk("busy", {11'h0, busy}, 12'h000);
		frame(ADDR_GENERAL, 12'h5a3, 4'h3, 8'h02, 2, 1'h0, RC_BC_START, RC_BC_END);
		chk("flag", {11'h0, flag}, 12'h000);
		chk("count", {4'h0, cnt}, 12'h002);
		chk("level", {6'h0, lvl}, 12'h005);
		rd(8'h5a);
		rd(8'h33);
		rd(8'h02);
		rd(8'hd0);
		rd(8'hd1);
		$display("test general done");
		set_en;
		u_far.send(1'h1, ADDR_GENERAL, 12'h111, 4'h3, 8'h01, 0, 1'h0);
		u_far.send(1'h0, 12'h123, 12'h111, 4'h3, 8'h01, 0, 1'h0);
		repeat (10) tick;
		chk("ignored", {10'h0, irq, empty}, 12'h001);
		frame(grp, 12'h7e1, 4'h6, 8'h03, 1, 1'h1, RC_BC_START, RC_BC_ABORT);
		chk("flag", {11'h0, flag}, 12'h000);
		chk("count", {4'h0, cnt}, 12'h001);
		rd(8'h7e);
		rd(8'h16);
		rd(8'h03);
		rd(8'hd0);
		$display("test group abort done");
		u_far.send(1'h0, ADDR_GENERAL, 12'h999, 4'h0, 8'h01, 0, 1'h0);
		repeat (10) tick;
		chk("silent", {11'h0, irq}, 12'h000);
		err_en = 1'h1;
		frame(ADDR_GENERAL, 12'habc, 4'h0, 8'h01, 0, 1'h0, RC_BC_ERROR, RC_RESET);
		chk("err addr", {ea2[3:0], ea1}, 12'habc);
		frame(grp, 12'h412, 4'h0, 8'h01, 0, 1'h0, RC_BC_ERROR, RC_RESET);
		chk("err addr", {ea2[3:0], ea1}, 12'h412);
		chk("err addr 2", {4'h0, ea2}, 12'h004);
		chk("empty", {11'h0, empty}, 12'h001);
		err_en = 1'h0;
		$display("test error done");
		multi_frame_capture_enable = 1'h1;
		set_en;
		frame(ADDR_GENERAL, 12'h135, 4'h2, 8'h01, 1, 1'h0, RC_BC_START, RC_BC_END);
		set_en;
		chk("busy", {11'h0, busy}, 12'h000);
		multi_frame_capture_enable = 1'h0;
		tick;
		tick;
		chk("busy", {11'h0, busy}, 12'h001);
		multi_frame_capture_enable = 1'h1;
		tick;
		tick;
		frame(grp, 12'h246, 4'h1, 8'h1e, 30, 1'h0, RC_BC_START, RC_BC_END);
		set_en;
		chk("level", {6'h0, lvl}, 12'h025);
		chk("busy", {11'h0, busy}, 12'h001);
		rd(8'h13);
		tick;
		chk("busy", {11'h0, busy}, 12'h000);
		drain;
		multi_frame_capture_enable = 1'h0;
		$display("test multi frame done");
		for (int m = 0; m < 2; m++)
		begin
			mode = m[0];
			w = m ? 10 : 20;
			set_en;
			fork
				u_far.send(1'h0, ADDR_GENERAL, 12'h5a3, 4'h3, 8'h28, 40, 1'h0);
				begin
					wait_code(RC_BC_START);
					wait_code(RC_BC_FULL);
					wait_code(RC_BC_ABORT);
					chk("stall wait", {11'h0, n > w - 4 && n < w + 3}, 12'h001);
				end
			join
			chk("flag", {11'h0, flag}, 12'h000);
			chk("count", {4'h0, cnt}, 12'h027);
			drain;
		end
		$display("test stall abort done");
		mode = 1'h0;
		set_en;
		fork
			u_far.send(1'h0, grp, 12'h6c9, 4'h5, 8'h28, 40, 1'h0);
			begin
				wait_code(RC_BC_START);
				wait_code(RC_BC_FULL);
				chk("level", {6'h0, lvl}, 12'h028);
				rd(8'h6c);
				wait_code(RC_BC_END);
			end
		join
		chk("count", {4'h0, cnt}, 12'h028);
		drain;
		$display("test stall resume done");
		wrap_up;
	end
endmodule
`default_nettype wire
